// File: rtl/rvam_vector_map.sv
`timescale 1ns/1ps
`include "rvam_params.svh"

// Functional notes
// - Unprogrammed fuse: every reset starts at zero
// - Programmed fuse: reset starts at boot address
// - Fuse one is unprogrammed, zero programmed
// - Select set: entries offset by boot start
// - Reset ignores select; first entry moves
// - External requests at 0x0002, 0x0004, 0x0006
// - Pin change 0x0008-0x000E; watchdog 0x0010
// - Timer two at 0x0012, 0x0014, 0x0016
// - Timer one at 0x0018 through 0x001E
// - Timer zero at 0x0020, 0x0022, 0x0024
// - Serial peripheral done at 0x0026
// - First serial port at 0x0028-0x002C
// - Comparator through program store 0x002E-0x0036
// - Second serial port at 0x0038-0x003C
// - Each entry spans two instruction words

module rvam_vector_map
  import rvam_pkg::*;
#(
  parameter int ADDR_W = `RVAM_ADDR_W,
  parameter int NUM_SRC = `RVAM_NUM_SRC,
  parameter int IDX_W = `RVAM_IDX_W,
  parameter int VEC_W = `RVAM_VEC_W
)
(
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Placement controls
  input wire logic boot_reset_fuse,
  input wire logic vector_table_select,
  input wire logic [ADDR_W-1:0] boot_reset_addr,
  // Requests from peripherals and the core's global enable
  input wire logic [NUM_SRC-1:0] irq_req,
  input wire logic irq_enable,
  // Fetch handshake with the core
  input wire logic fetch_ack,
  output logic fetch_valid,
  output logic fetch_is_reset,
  output logic [ADDR_W-1:0] fetch_addr,
  output logic [VEC_W-1:0] vector_num,
  // Acknowledge back to the dispatched source
  output logic [NUM_SRC-1:0] irq_taken
);

  // ****************************************
  // State
  // ****************************************
  rvam_state_t state;
  rvam_state_t next_state;
  logic next_fetch_valid;
  logic next_fetch_is_reset;
  logic [ADDR_W-1:0] next_fetch_addr;
  logic [VEC_W-1:0] next_vector_num;
  logic [NUM_SRC-1:0] next_irq_taken;
  logic [IDX_W-1:0] src_idx;
  logic [IDX_W-1:0] next_src_idx;
  logic table_sel;
  logic next_table_sel;

  logic pend_found;
  logic [IDX_W-1:0] pend_idx;
  logic [ADDR_W-1:0] pend_addr;
  logic [ADDR_W-1:0] reset_addr;

  // ****************************************
  // Arbitration and address mapping
  // ****************************************
  rvam_prio_enc #(
    .N(NUM_SRC),
    .IDX_W(IDX_W)
  ) u_prio (
    .req(irq_req),
    .found(pend_found),
    .idx(pend_idx)
  );

  // Base table follows from index order and stride
  rvam_vec_addr #(
    .ADDR_W(ADDR_W),
    .IDX_W(IDX_W)
  ) u_addr (
    .src_idx(pend_idx),
    .table_sel(vector_table_select),
    .boot_base(boot_reset_addr),
    .addr(pend_addr)
  );

  // Reset entry looks only at the fuse, never at the table select
  assign reset_addr = (boot_reset_fuse == `RVAM_FUSE_PROGRAMMED) ? boot_reset_addr
                                                                 : ADDR_W'(`RVAM_APP_RESET_ADDR);

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb
  begin
    next_state = state;
    next_fetch_valid = fetch_valid;
    next_fetch_is_reset = fetch_is_reset;
    next_fetch_addr = fetch_addr;
    next_vector_num = vector_num;
    next_src_idx = src_idx;
    next_table_sel = table_sel;
    next_irq_taken = '0;
    case (state)
      ST_RESET:
      begin
        // Fuse is read on the first enabled edge after release
        next_fetch_addr = reset_addr;
        next_fetch_valid = 1'b1;
        next_fetch_is_reset = 1'b1;
        next_vector_num = `RVAM_RESET_VEC;
        next_state = ST_OFFER;
      end
      ST_IDLE:
      begin
        if (irq_enable && pend_found)
        begin
          next_fetch_addr = pend_addr;
          next_fetch_valid = 1'b1;
          next_fetch_is_reset = 1'b0;
          next_vector_num = VEC_W'(pend_idx) + `RVAM_FIRST_IRQ_VEC;
          next_src_idx = pend_idx;
          next_table_sel = vector_table_select;
          next_state = ST_OFFER;
        end
      end
      ST_OFFER:
      begin
        // Address holds until the core takes it
        if (fetch_ack)
        begin
          next_fetch_valid = 1'b0;
          if (!fetch_is_reset)
          begin
            next_irq_taken[src_idx] = 1'b1;
          end
          next_state = ST_IDLE;
        end
      end
      default:
      begin
        next_state = ST_RESET;
        next_fetch_valid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state <= ST_RESET;
      fetch_valid <= 1'b0;
      fetch_is_reset <= 1'b0;
      fetch_addr <= '0;
      vector_num <= '0;
      src_idx <= '0;
      table_sel <= 1'b0;
      irq_taken <= '0;
    end
    else if (clk_en)
    begin
      state <= next_state;
      fetch_valid <= next_fetch_valid;
      fetch_is_reset <= next_fetch_is_reset;
      fetch_addr <= next_fetch_addr;
      vector_num <= next_vector_num;
      src_idx <= next_src_idx;
      table_sel <= next_table_sel;
      irq_taken <= next_irq_taken;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  logic [ADDR_W-1:0] offer_base;
  logic offer_irq;

  // Offset of the offered entry with the boot relocation removed
  assign offer_base = table_sel ? ADDR_W'(fetch_addr - boot_reset_addr) : fetch_addr;
  assign offer_irq = fetch_valid && !fetch_is_reset;

  AST_APP_RESET: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == ST_RESET && clk_en && boot_reset_fuse)
    |=> (fetch_valid && fetch_is_reset && fetch_addr == ADDR_W'(`RVAM_APP_RESET_ADDR)))
    else $error("Unprogrammed fuse did not start at zero");

  AST_BOOT_RESET: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == ST_RESET && clk_en && !boot_reset_fuse)
    |=> (fetch_valid && fetch_is_reset && fetch_addr == $past(boot_reset_addr)))
    else $error("Programmed fuse did not start at boot address");

  AST_RESET_NO_SELECT: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == ST_RESET && clk_en && boot_reset_fuse && vector_table_select)
    |=> (fetch_addr == ADDR_W'(`RVAM_APP_RESET_ADDR)))
    else $error("Table select moved the reset entry");

  AST_FIRST_ENTRY: assert property (@(posedge core_clk) disable iff (!rst_n)
    (offer_irq && vector_num == `RVAM_FIRST_IRQ_VEC)
    |-> (fetch_addr == (table_sel ? ADDR_W'(boot_reset_addr + ADDR_W'(`RVAM_BASE_EXT_IRQ))
                                  : ADDR_W'(`RVAM_BASE_EXT_IRQ))))
    else $error("First entry misplaced");

  AST_RELOCATE: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == ST_IDLE && clk_en && irq_enable && pend_found && vector_table_select)
    |=> (fetch_addr == ADDR_W'(boot_reset_addr + ADDR_W'((32'(vector_num) - 32'h1) * `RVAM_VEC_STRIDE))))
    else $error("Relocated entry not offset by boot start");

  AST_STRIDE: assert property (@(posedge core_clk) disable iff (!rst_n)
    offer_irq |-> (offer_base == ADDR_W'((32'(vector_num) - 32'h1) * `RVAM_VEC_STRIDE)))
    else $error("Entry spacing is not two words");

  AST_EXT_IRQ: assert property (@(posedge core_clk) disable iff (!rst_n)
    (offer_irq && src_idx == SRC_EXT_IRQ_2)
    |-> (offer_base == ADDR_W'(`RVAM_BASE_EXT_IRQ_LAST)))
    else $error("External request entry wrong");

  AST_PIN_WDOG: assert property (@(posedge core_clk) disable iff (!rst_n)
    (offer_irq && (src_idx == SRC_PIN_CHANGE_GROUP_0 || src_idx == SRC_PIN_CHANGE_GROUP_3
                   || src_idx == SRC_WATCHDOG_TIMEOUT))
    |-> (offer_base == (src_idx == SRC_PIN_CHANGE_GROUP_0 ? ADDR_W'(`RVAM_BASE_PIN_CHANGE)
                       : src_idx == SRC_PIN_CHANGE_GROUP_3 ? ADDR_W'(`RVAM_BASE_PIN_CHANGE_LAST)
                       : ADDR_W'(`RVAM_BASE_WATCHDOG))))
    else $error("Pin change or watchdog entry wrong");

  AST_TC2: assert property (@(posedge core_clk) disable iff (!rst_n)
    (offer_irq && src_idx == SRC_TC2_MATCH_A) |-> (offer_base == ADDR_W'(`RVAM_BASE_TC2)))
    else $error("Timer two entry wrong");

  AST_TC1: assert property (@(posedge core_clk) disable iff (!rst_n)
    (offer_irq && (src_idx == SRC_TC1_CAPTURE || src_idx == SRC_TC1_OVERFLOW))
    |-> (offer_base == (src_idx == SRC_TC1_CAPTURE ? ADDR_W'(`RVAM_BASE_TC1)
                                                    : ADDR_W'(`RVAM_BASE_TC1_OVF))))
    else $error("Timer one entry wrong");

  AST_TC0: assert property (@(posedge core_clk) disable iff (!rst_n)
    (offer_irq && src_idx == SRC_TC0_MATCH_A) |-> (offer_base == ADDR_W'(`RVAM_BASE_TC0)))
    else $error("Timer zero entry wrong");

  AST_SERIAL_PERIPH: assert property (@(posedge core_clk) disable iff (!rst_n)
    (offer_irq && src_idx == SRC_SERIAL_PERIPH_DONE)
    |-> (offer_base == ADDR_W'(`RVAM_BASE_SERIAL_PERIPH)))
    else $error("Serial peripheral entry wrong");

  AST_UART0: assert property (@(posedge core_clk) disable iff (!rst_n)
    (offer_irq && src_idx == SRC_UART0_RX_DONE) |-> (offer_base == ADDR_W'(`RVAM_BASE_UART0)))
    else $error("First serial port entry wrong");

  AST_MISC: assert property (@(posedge core_clk) disable iff (!rst_n)
    (offer_irq && (src_idx == SRC_ANALOG_COMPARE || src_idx == SRC_PROGRAM_STORE_READY))
    |-> (offer_base == (src_idx == SRC_ANALOG_COMPARE ? ADDR_W'(`RVAM_BASE_MISC)
                                                       : ADDR_W'(`RVAM_BASE_PROGRAM_STORE))))
    else $error("Comparator or program store entry wrong");

  AST_UART1: assert property (@(posedge core_clk) disable iff (!rst_n)
    (offer_irq && (src_idx == SRC_UART1_RX_DONE || src_idx == SRC_UART1_TX_DONE))
    |-> (offer_base == (src_idx == SRC_UART1_RX_DONE ? ADDR_W'(`RVAM_BASE_UART1)
                                                      : ADDR_W'(`RVAM_BASE_UART1_LAST))))
    else $error("Second serial port entry wrong");

  AST_TC2_REST: assert property (@(posedge core_clk) disable iff (!rst_n)
    (offer_irq && (src_idx == SRC_TC2_MATCH_B || src_idx == SRC_TC2_OVERFLOW))
    |-> (offer_base == (src_idx == SRC_TC2_MATCH_B ? ADDR_W'(`RVAM_BASE_TC2_B)
                                                    : ADDR_W'(`RVAM_BASE_TC2_OVF))))
    else $error("Timer two match B or overflow entry wrong");

  AST_TC1_MATCH: assert property (@(posedge core_clk) disable iff (!rst_n)
    (offer_irq && (src_idx == SRC_TC1_MATCH_A || src_idx == SRC_TC1_MATCH_B))
    |-> (offer_base == (src_idx == SRC_TC1_MATCH_A ? ADDR_W'(`RVAM_BASE_TC1_A)
                                                    : ADDR_W'(`RVAM_BASE_TC1_B))))
    else $error("Timer one compare entry wrong");

  AST_TC0_REST: assert property (@(posedge core_clk) disable iff (!rst_n)
    (offer_irq && (src_idx == SRC_TC0_MATCH_B || src_idx == SRC_TC0_OVERFLOW))
    |-> (offer_base == (src_idx == SRC_TC0_MATCH_B ? ADDR_W'(`RVAM_BASE_TC0_B)
                                                    : ADDR_W'(`RVAM_BASE_TC0_OVF))))
    else $error("Timer zero match B or overflow entry wrong");

  AST_UART0_REST: assert property (@(posedge core_clk) disable iff (!rst_n)
    (offer_irq && (src_idx == SRC_UART0_TX_EMPTY || src_idx == SRC_UART0_TX_DONE))
    |-> (offer_base == (src_idx == SRC_UART0_TX_EMPTY ? ADDR_W'(`RVAM_BASE_UART0_TX_EMPTY)
                                                       : ADDR_W'(`RVAM_BASE_UART0_TX_DONE))))
    else $error("First serial port transmit entry wrong");

  AST_MISC_MID: assert property (@(posedge core_clk) disable iff (!rst_n)
    (offer_irq && (src_idx == SRC_CONVERTER_DONE || src_idx == SRC_EEPROM_READY
                   || src_idx == SRC_TWO_WIRE_DONE))
    |-> (offer_base == (src_idx == SRC_CONVERTER_DONE ? ADDR_W'(`RVAM_BASE_CONVERTER)
                       : src_idx == SRC_EEPROM_READY ? ADDR_W'(`RVAM_BASE_EEPROM)
                       : ADDR_W'(`RVAM_BASE_TWO_WIRE))))
    else $error("Converter, memory or two-wire entry wrong");

  AST_UART1_EMPTY: assert property (@(posedge core_clk) disable iff (!rst_n)
    (offer_irq && src_idx == SRC_UART1_TX_EMPTY) |-> (offer_base == ADDR_W'(`RVAM_BASE_UART1_TX_EMPTY)))
    else $error("Second serial port empty entry wrong");

  AST_LOWEST_WINS: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == ST_IDLE && clk_en && irq_enable && irq_req[0])
    |=> (fetch_valid && vector_num == `RVAM_FIRST_IRQ_VEC))
    else $error("Lowest pending request not chosen");

  AST_HOLD_OFFER: assert property (@(posedge core_clk) disable iff (!rst_n)
    (fetch_valid && !(fetch_ack && clk_en)) |=> (fetch_valid && $stable(fetch_addr)))
    else $error("Offered address dropped before acknowledge");

  AST_TAKEN_PULSE: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == ST_OFFER && clk_en && fetch_ack && !fetch_is_reset)
    |=> ($onehot(irq_taken) && !fetch_valid) ##1 (irq_taken == '0 || !$past(clk_en)))
    else $error("Acknowledge to source not a single pulse");

endmodule : rvam_vector_map

// File: rtl/rvam_params.svh
`ifndef RVAM_PARAMS_SVH
`define RVAM_PARAMS_SVH

// ****************************************
// Address map geometry
// ****************************************
`define RVAM_ADDR_W 17
`define RVAM_NUM_SRC 30
`define RVAM_IDX_W 5
`define RVAM_VEC_W 5
`define RVAM_VEC_STRIDE 32'h2
`define RVAM_APP_RESET_ADDR 17'h00000
`define RVAM_FUSE_PROGRAMMED 1'b0
`define RVAM_RESET_VEC 5'h01
`define RVAM_FIRST_IRQ_VEC 5'h02

// ****************************************
// Group start and end addresses in the base table
// ****************************************
`define RVAM_BASE_EXT_IRQ 17'h00002
`define RVAM_BASE_PIN_CHANGE 17'h00008
`define RVAM_BASE_PIN_CHANGE_LAST 17'h0000E
`define RVAM_BASE_WATCHDOG 17'h00010
`define RVAM_BASE_TC2 17'h00012
`define RVAM_BASE_TC1 17'h00018
`define RVAM_BASE_TC1_OVF 17'h0001E
`define RVAM_BASE_TC0 17'h00020
`define RVAM_BASE_SERIAL_PERIPH 17'h00026
`define RVAM_BASE_UART0 17'h00028
`define RVAM_BASE_MISC 17'h0002E
`define RVAM_BASE_PROGRAM_STORE 17'h00036
`define RVAM_BASE_UART1 17'h00038
`define RVAM_BASE_UART1_LAST 17'h0003C

// ****************************************
// Other entries of the groups
// ****************************************
`define RVAM_BASE_EXT_IRQ_LAST 17'h00006
`define RVAM_BASE_TC2_B 17'h00014
`define RVAM_BASE_TC2_OVF 17'h00016
`define RVAM_BASE_TC1_A 17'h0001A
`define RVAM_BASE_TC1_B 17'h0001C
`define RVAM_BASE_TC0_B 17'h00022
`define RVAM_BASE_TC0_OVF 17'h00024
`define RVAM_BASE_UART0_TX_EMPTY 17'h0002A
`define RVAM_BASE_UART0_TX_DONE 17'h0002C
`define RVAM_BASE_CONVERTER 17'h00030
`define RVAM_BASE_EEPROM 17'h00032
`define RVAM_BASE_TWO_WIRE 17'h00034
`define RVAM_BASE_UART1_TX_EMPTY 17'h0003A

`endif

// File: rtl/rvam_pkg.sv
package rvam_pkg;

  // ****************************************
  // Source index of each request line
  // ****************************************
  typedef enum logic [4:0] {
    SRC_EXT_IRQ_0 = 5'h00, SRC_EXT_IRQ_1 = 5'h01, SRC_EXT_IRQ_2 = 5'h02,
    SRC_PIN_CHANGE_GROUP_0 = 5'h03, SRC_PIN_CHANGE_GROUP_1 = 5'h04, SRC_PIN_CHANGE_GROUP_2 = 5'h05,
    SRC_PIN_CHANGE_GROUP_3 = 5'h06, SRC_WATCHDOG_TIMEOUT = 5'h07, SRC_TC2_MATCH_A = 5'h08,
    SRC_TC2_MATCH_B = 5'h09, SRC_TC2_OVERFLOW = 5'h0A, SRC_TC1_CAPTURE = 5'h0B,
    SRC_TC1_MATCH_A = 5'h0C, SRC_TC1_MATCH_B = 5'h0D, SRC_TC1_OVERFLOW = 5'h0E,
    SRC_TC0_MATCH_A = 5'h0F, SRC_TC0_MATCH_B = 5'h10, SRC_TC0_OVERFLOW = 5'h11,
    SRC_SERIAL_PERIPH_DONE = 5'h12, SRC_UART0_RX_DONE = 5'h13, SRC_UART0_TX_EMPTY = 5'h14,
    SRC_UART0_TX_DONE = 5'h15, SRC_ANALOG_COMPARE = 5'h16, SRC_CONVERTER_DONE = 5'h17,
    SRC_EEPROM_READY = 5'h18, SRC_TWO_WIRE_DONE = 5'h19, SRC_PROGRAM_STORE_READY = 5'h1A,
    SRC_UART1_RX_DONE = 5'h1B, SRC_UART1_TX_EMPTY = 5'h1C, SRC_UART1_TX_DONE = 5'h1D
  } rvam_src_t;

  // ****************************************
  // Dispatch sequencer states
  // ****************************************
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_IDLE = 2'b01,
    ST_OFFER = 2'b10
  } rvam_state_t;

endpackage : rvam_pkg

// File: rtl/rvam_prio_enc.sv
`timescale 1ns/1ps
`include "rvam_params.svh"

module rvam_prio_enc
  import rvam_pkg::*;
#(
  parameter int N = `RVAM_NUM_SRC,
  parameter int IDX_W = `RVAM_IDX_W
)
(
  // Requests
  input wire logic [N-1:0] req,
  // Winner
  output logic found,
  output logic [IDX_W-1:0] idx
);

  // Lowest index wins: scan downward so the last hit kept is the lowest
  always_comb
  begin
    found = 1'b0;
    idx = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        found = 1'b1;
        idx = IDX_W'(i);
      end
    end
  end

endmodule : rvam_prio_enc

// File: rtl/rvam_vec_addr.sv
`timescale 1ns/1ps
`include "rvam_params.svh"

module rvam_vec_addr
  import rvam_pkg::*;
#(
  parameter int ADDR_W = `RVAM_ADDR_W,
  parameter int IDX_W = `RVAM_IDX_W
)
(
  // Source and placement
  input wire logic [IDX_W-1:0] src_idx,
  input wire logic table_sel,
  input wire logic [ADDR_W-1:0] boot_base,
  // Entry address
  output logic [ADDR_W-1:0] addr
);

  logic [ADDR_W-1:0] base;

  // Two words per entry, source 0 sits one entry above reset
  assign base = ADDR_W'((32'(src_idx) + 32'h1) * `RVAM_VEC_STRIDE);
  assign addr = table_sel ? ADDR_W'(boot_base + base) : base;

endmodule : rvam_vec_addr

// File: tb/rvam_core_model.sv
`timescale 1ns/1ps

// ****************************************
// Core fetch side: accepts an offer after a set wait
// ****************************************
module rvam_core_model
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Offer from the map and wait length
  input wire logic fetch_valid,
  input wire logic [3:0] ack_dly,
  // Accept
  output logic fetch_ack = 1'b0
);
  logic [3:0] wait_cnt = 4'h0;

  // Ack only while an offer stands, so it never leaks into the next offer
  always @(negedge core_clk)
  begin
    if (!rst_n || !fetch_valid)
    begin
      wait_cnt <= 4'h0;
      fetch_ack <= 1'b0;
    end
    else
    begin
      fetch_ack <= (wait_cnt >= ack_dly);
      if (wait_cnt != 4'hF)
        wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule : rvam_core_model

// File: tb/reset_and_vector_address_map_bench.sv
`timescale 1ns/1ps
`include "rvam_params.svh"

`define CHK(a, b) \
  begin \
    compares++; \
    if ((a) !== (b)) \
    begin \
      n_fail++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); \
    end \
  end

module reset_and_vector_address_map_bench;
  import rvam_pkg::*;

  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic boot_reset_fuse = 1'b1;
  logic vector_table_select = 1'b0;
  logic [`RVAM_ADDR_W-1:0] boot_reset_addr = 17'h1F000;
  logic [`RVAM_NUM_SRC-1:0] irq_req = 30'h0;
  logic irq_enable = 1'b0;
  logic fetch_ack;
  logic fetch_valid;
  logic fetch_is_reset;
  logic [`RVAM_ADDR_W-1:0] fetch_addr;
  logic [`RVAM_VEC_W-1:0] vector_num;
  logic [`RVAM_NUM_SRC-1:0] irq_taken;
  logic [`RVAM_NUM_SRC-1:0] raise = 30'h0;
  logic [`RVAM_NUM_SRC-1:0] taken_exp = 30'h0;
  logic taken_due = 1'b0;
  logic [3:0] ack_dly = 4'h0;
  logic [22:0] exp_q[$];
  logic [22:0] got;
  logic [22:0] exp_v;
  int n_fail = 0;
  int compares = 0;

  always #50 core_clk = ~core_clk;

  rvam_vector_map i_rvam_vector_map (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
    .boot_reset_fuse(boot_reset_fuse), .vector_table_select(vector_table_select),
    .boot_reset_addr(boot_reset_addr), .irq_req(irq_req), .irq_enable(irq_enable),
    .fetch_ack(fetch_ack), .fetch_valid(fetch_valid), .fetch_is_reset(fetch_is_reset),
    .fetch_addr(fetch_addr), .vector_num(vector_num), .irq_taken(irq_taken)
  );

  rvam_core_model i_rvam_core_model (
    .core_clk(core_clk), .rst_n(rst_n), .fetch_valid(fetch_valid),
    .ack_dly(ack_dly), .fetch_ack(fetch_ack)
  );

  // ****************************************
  // Sources: hold until taken, then drop
  // ****************************************
  always @(negedge core_clk)
  begin
    irq_req <= (irq_req & ~irq_taken) | raise;
  end

  // ****************************************
  // Monitor: compare each accepted offer with the oldest note
  // ****************************************
  always @(posedge core_clk)
  begin
    if (rst_n && clk_en)
    begin
      if (taken_due)
      begin
        `CHK(irq_taken, taken_exp)
        taken_due = 1'b0;
      end
      else
        `CHK(irq_taken, 30'h0)
      if (fetch_valid && fetch_ack)
      begin
        got = {fetch_is_reset, vector_num, fetch_addr};
        exp_v = (exp_q.size() != 0) ? exp_q.pop_front() : 23'h7FFFFF;
        `CHK(got, exp_v)
        `CHK(got[16:0], exp_v[16:0])
        taken_due = !fetch_is_reset;
        taken_exp = 30'h1 << (exp_v[21:17] - 5'h02);
      end
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic do_reset(input logic fuse_val, input logic [16:0] addr);
    @(negedge core_clk);
    rst_n = 1'b0;
    boot_reset_fuse = fuse_val;
    boot_reset_addr = addr;
    repeat (20) @(negedge core_clk);
    rst_n = 1'b1;
    exp_q.push_back({1'b1, 5'h01, fuse_val ? 17'h00000 : addr});
  endtask : do_reset

  task automatic fire(input logic [29:0] mask);
    @(negedge core_clk);
    raise <= mask;
    // Lowest source first, as they are all pending together
    for (int i = 0; i < 30; i++)
      if (mask[i])
        exp_q.push_back({1'b0, 5'(i + 2), 17'(2 * (i + 1)) + (vector_table_select ? boot_reset_addr : 17'h0)});
    // Pulse of one cycle on the sources, taken up at this falling edge
    @(negedge core_clk);
    raise <= 30'h0;
  endtask : fire

  task automatic drain();
    int n;
    n = 0;
    while ((exp_q.size() != 0 || taken_due || fetch_valid) && n < 2000)
    begin
      @(negedge core_clk);
      n++;
    end
    `CHK(n < 2000, 1'b1)
    repeat (2) @(negedge core_clk);
  endtask : drain

  task automatic final_report();
    $display("Counts: %0d compares, %0d mismatches", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report

  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    void'($urandom(32'h0B9C));
    do_reset(1'b1, 17'h1F000);
    irq_enable = 1'b1;
    for (int i = 0; i < 30; i++)
    begin
      ack_dly = 4'($urandom % 4);
      fire(30'h1 << i);
      drain();
    end
    // Several pending at once, table moved up
    vector_table_select = 1'b1;
    repeat (3)
    begin
      ack_dly = 4'($urandom % 4);
      fire(30'($urandom));
      drain();
    end
    // Global gate closed: request must wait
    irq_enable = 1'b0;
    fire(30'h0000_0030);
    repeat (8)
    begin
      @(negedge core_clk);
      `CHK(fetch_valid, 1'b0)
    end
    irq_enable = 1'b1;
    drain();
    // Clock enable low while an ack is pending must hold the offer
    ack_dly = 4'h1;
    fire(30'h2000_0000);
    repeat (2) @(negedge core_clk);
    clk_en = 1'b0;
    repeat (5)
    begin
      @(negedge core_clk);
      `CHK(fetch_valid, 1'b1)
    end
    clk_en = 1'b1;
    drain();
    // Programmed fuse, select still set during reset
    do_reset(1'b0, 17'h1F000 - 17'(($urandom % 8) * 17'h01000));
    drain();
    fire(30'h0000_0001);
    drain();
    // Unprogrammed fuse with select still set: reset stays at zero
    do_reset(1'b1, 17'h1F000);
    drain();
    vector_table_select = 1'b0;
    fire(30'($urandom));
    drain();
    final_report();
  end

  // Watchdog at 30000 cycles, well beyond the expected run of several hundred cycles
  initial
  begin
    #3000000;
    n_fail++;
    final_report();
  end
endmodule : reset_and_vector_address_map_bench
